// [hdl/prc_defs.svh]
// Constants for the reset, clock-out and media pair sequencer
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// Core clock rate in kHz (40 MHz)
`define PRC_CLK_KHZ 40000
// Longest completion time after reset or powerdown release, in us (5 ms)
`define PRC_SETTLE_US 5000
// Crossover hunt dwell time per configuration, in us
`define PRC_XOVER_US 100

// Counter and field widths and pair count held in the state types
`define PRC_TMR_W 20
`define PRC_XCNT_W 16
`define PRC_CFG_W 8
`define PRC_ADDR_W 5
`define PRC_PAIRS 4

// Pair masks
`define PRC_PAIR_NONE 4'h0
`define PRC_PAIR_ALL 4'hF
`define PRC_PAIR_ZERO 4'h1
`define PRC_PAIR_ONE 4'h2
`define PRC_PAIR_UPPER 4'hC

// Strap defaults held before the first sample
`define PRC_AUTOX_DEFAULT 1'b1
`define PRC_MDIX_DEFAULT 1'b0
`define PRC_ADDR_DEFAULT 5'h00
`define PRC_CFG_DEFAULT 8'h00

`endif

// [hdl/prc_pkg.sv]
// Types for the reset, clock-out and media pair sequencer
`default_nettype none
`include "prc_defs.svh"

package prc_pkg;

   typedef enum logic [1:0] {
      PRC_HELD,
      PRC_SETTLE,
      PRC_RUN
   } prc_phase_t;

   typedef struct packed {
      prc_phase_t phase;
      logic core_rst_n;
      logic clk_strap_en;
      logic clk_out_en;
      logic autox;
      logic mdix_fixed;
      logic mdix;
      logic [`PRC_XCNT_W-1:0] xcnt;
      logic [`PRC_ADDR_W-1:0] phy_addr;
      logic [`PRC_CFG_W-1:0] cfg;
      logic [`PRC_PAIRS-1:0] tx_en;
      logic [`PRC_PAIRS-1:0] rx_en;
   } prc_state_t;

   typedef struct packed {
      logic [`PRC_TMR_W-1:0] count;
      logic armed;
   } prc_timer_state_t;

endpackage : prc_pkg

`default_nettype wire

// [hdl/prc_timer_if.sv]
// Handshake between the sequencer and its settle timer
`default_nettype none

interface prc_timer_if;
   logic hold;
   logic busy;
   logic done;

   modport owner (output hold, input busy, input done);
   modport timer (input hold, output busy, output done);
endinterface : prc_timer_if

`default_nettype wire

// [hdl/prc_settle_timer.sv]
// Completion timer: reloads while held, counts down after release
`default_nettype none
`include "prc_defs.svh"

module prc_settle_timer #(
   parameter int unsigned CYCLES = 200000
) (
   input wire logic i_clk,        // Core clock
   input wire logic i_resetn,     // Async reset, active low
   prc_timer_if.timer tmr         // Hold in, busy and done out
);

   localparam logic [`PRC_TMR_W-1:0] LOAD = (`PRC_TMR_W)'(CYCLES - 1);

   generate
      if (CYCLES < 2 || CYCLES > (1 << `PRC_TMR_W)) begin : g_bad
         $error("prc_settle_timer: CYCLES out of range");
      end
   endgenerate

   prc_pkg::prc_timer_state_t q_reg;
   prc_pkg::prc_timer_state_t q_next;

   always_comb begin
      q_next = q_reg;
      if (tmr.hold) begin
         q_next.count = LOAD;
         q_next.armed = 1'b1;
      end else if (q_reg.armed) begin
         if (q_reg.count == '0) begin
            q_next.armed = 1'b0;
         end else begin
            q_next.count = q_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q_reg <= '{count: LOAD, armed: 1'b1};
      end else begin
         q_reg <= q_next;
      end
   end

   assign tmr.busy = q_reg.armed;
   assign tmr.done = q_reg.armed && !tmr.hold && (q_reg.count == '0);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   chk_timer_reload: assert property (
      tmr.hold |=> q_reg.armed && q_reg.count == LOAD)
      else $error("settle timer did not reload while held");

   chk_timer_step: assert property (
      !tmr.hold && q_reg.armed && q_reg.count != '0 ##1 !tmr.hold
      |-> q_reg.count == $past(q_reg.count) - 1'b1)
      else $error("settle timer did not count down");

endmodule : prc_settle_timer

`default_nettype wire

// [hdl/phy_reset_clock_pair_map.sv]
// Reset, powerdown, clock-out enable and media pair direction control
`default_nettype none
`include "prc_defs.svh"

// Summary of operation
// - at gigabit speed all four pairs transmit and receive together
// - 10/100: pair zero transmits when straight, receives when crossed
// - 10/100: pair one receives when straight, transmits when crossed
// - 10/100: pairs two and three carry nothing
// - straight or crossed choice is made internally by hunting for link
// - when enabled, a 125 MHz clock is offered to the MAC
// - the MAC clock output is off unless enabled
// - MAC clock enabled by the low-active strap or by management request
// - strap sampled during reset; clock runs through reset if asserted
// - all reset activity completes within 5 ms of reset release
// - configuration and address straps are latched during reset
// - all reset activity completes within 5 ms of powerdown release
// - every function stays inactive while powerdown is asserted
// - configuration and address straps are latched during powerdown
// - with auto crossover strapped off, a second strap fixes the pairing
module phy_reset_clock_pair_map #(
   parameter int unsigned SETTLE_CYCLES =
      (`PRC_SETTLE_US * `PRC_CLK_KHZ) / 1000,
   parameter int unsigned XOVER_CYCLES =
      (`PRC_XOVER_US * `PRC_CLK_KHZ) / 1000
) (
   input wire logic i_clk,                         // 40 MHz core clock
   input wire logic i_resetn,                      // Async power-on reset
   input wire logic i_hw_reset_n,                  // Reset pin, low active
   input wire logic i_hw_powerdown_in,             // Powerdown pin, high
   input wire logic i_mac_clock_enable_strap_n,    // Clock-out strap, low
   input wire logic i_mgmt_clock_enable,           // Management clock req
   input wire logic i_autox_strap,                 // 1 = auto crossover
   input wire logic i_mdix_strap,                  // 0 straight, 1 crossed
   input wire logic [`PRC_ADDR_W-1:0] i_phy_addr_strap, // Address straps
   input wire logic [`PRC_CFG_W-1:0] i_config_strap,    // Config straps
   input wire logic i_speed_gig,                   // 1 = gigabit speed
   input wire logic i_link_ok,                     // Link established
   output logic o_core_reset_n,                    // Core reset, low
   output logic o_ready,                           // Sequence complete
   output logic o_mac_clock_out_enable,            // Gate for 125 MHz out
   output logic o_mdix_active,                     // 1 = crossed pairing
   output logic [`PRC_PAIRS-1:0] o_media_pair_tx_en, // Per-pair transmit
   output logic [`PRC_PAIRS-1:0] o_media_pair_rx_en, // Per-pair receive
   output logic [`PRC_ADDR_W-1:0] o_phy_addr,      // Latched address
   output logic [`PRC_CFG_W-1:0] o_config          // Latched config
);

   localparam logic [`PRC_XCNT_W-1:0] XOVER_LAST =
      (`PRC_XCNT_W)'(XOVER_CYCLES - 1);

   generate
      if (XOVER_CYCLES < 2 || XOVER_CYCLES > (1 << `PRC_XCNT_W)) begin : g_bx
         $error("phy_reset_clock_pair_map: XOVER_CYCLES out of range");
      end
      if (SETTLE_CYCLES < 2 || SETTLE_CYCLES > (1 << `PRC_TMR_W)) begin : g_bs
         $error("phy_reset_clock_pair_map: SETTLE_CYCLES out of range");
      end
   endgenerate

   prc_timer_if tmr ();

   prc_settle_timer #(
      .CYCLES (SETTLE_CYCLES)
   ) u_settle (
      .i_clk (i_clk),
      .i_resetn (i_resetn),
      .tmr (tmr.timer)
   );

   prc_pkg::prc_state_t q_reg;
   prc_pkg::prc_state_t q_next;

   logic held;
   logic run_next;
   logic mdix_next;

   // Either pin alone holds the core; powerdown also covers reset pin
   assign held = !i_hw_reset_n || i_hw_powerdown_in;
   // Timer reloads for as long as either pin is active
   assign tmr.hold = held;

   always_comb begin
      q_next = q_reg;
      case (q_reg.phase)
         prc_pkg::PRC_HELD: begin
            q_next.core_rst_n = 1'b0;
            // Straps follow the pins only while a pin holds; the release
            // edge is already outside reset and must not resample them
            if (held) begin
               q_next.phy_addr = i_phy_addr_strap;
               q_next.cfg = i_config_strap;
               q_next.autox = i_autox_strap;
               q_next.mdix_fixed = i_mdix_strap;
            end
            if (!i_hw_reset_n) begin
               q_next.clk_strap_en = !i_mac_clock_enable_strap_n;
            end
            if (!held) begin
               q_next.phase = prc_pkg::PRC_SETTLE;
            end
         end
         prc_pkg::PRC_SETTLE: begin
            q_next.core_rst_n = 1'b0;
            if (held) begin
               q_next.phase = prc_pkg::PRC_HELD;
            end else if (tmr.done) begin
               // Release with the latched fixed pairing, or straight when auto crossover is on
               q_next.phase = prc_pkg::PRC_RUN;
               q_next.core_rst_n = 1'b1;
               q_next.mdix = q_reg.autox ?
                  `PRC_MDIX_DEFAULT : q_reg.mdix_fixed;
               q_next.xcnt = '0;
            end
         end
         prc_pkg::PRC_RUN: begin
            if (held) begin
               q_next.phase = prc_pkg::PRC_HELD;
               q_next.core_rst_n = 1'b0;
            end else if (!q_reg.autox) begin
               q_next.mdix = q_reg.mdix_fixed;
               q_next.xcnt = '0;
            end else if (i_link_ok) begin
               // While a link is up the pairing is left alone
               q_next.xcnt = '0;
            end else if (q_reg.xcnt == XOVER_LAST) begin
               q_next.xcnt = '0;
               q_next.mdix = !q_reg.mdix;
            end else begin
               q_next.xcnt = q_reg.xcnt + 1'b1;
            end
         end
         default: begin
            q_next.phase = prc_pkg::PRC_HELD;
            q_next.core_rst_n = 1'b0;
         end
      endcase

      run_next = (q_next.phase == prc_pkg::PRC_RUN);
      mdix_next = q_next.mdix;

      // Clock gate: powerdown wins, as it disables every function
      if (i_hw_powerdown_in) begin
         q_next.clk_out_en = 1'b0;
      end else if (!i_hw_reset_n) begin
         q_next.clk_out_en = !i_mac_clock_enable_strap_n;
      end else begin
         q_next.clk_out_en = q_next.clk_strap_en ||
            (run_next && i_mgmt_clock_enable);
      end

      // Pair directions only while the core is out of reset
      if (!run_next) begin
         q_next.tx_en = `PRC_PAIR_NONE;
         q_next.rx_en = `PRC_PAIR_NONE;
      end else if (i_speed_gig) begin
         q_next.tx_en = `PRC_PAIR_ALL;
         q_next.rx_en = `PRC_PAIR_ALL;
      end else if (mdix_next) begin
         q_next.tx_en = `PRC_PAIR_ONE;
         q_next.rx_en = `PRC_PAIR_ZERO;
      end else begin
         q_next.tx_en = `PRC_PAIR_ZERO;
         q_next.rx_en = `PRC_PAIR_ONE;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q_reg.phase <= prc_pkg::PRC_HELD;
         q_reg.core_rst_n <= 1'b0;
         q_reg.clk_strap_en <= 1'b0;
         q_reg.clk_out_en <= 1'b0;
         q_reg.autox <= `PRC_AUTOX_DEFAULT;
         q_reg.mdix_fixed <= `PRC_MDIX_DEFAULT;
         q_reg.mdix <= `PRC_MDIX_DEFAULT;
         q_reg.xcnt <= '0;
         q_reg.phy_addr <= `PRC_ADDR_DEFAULT;
         q_reg.cfg <= `PRC_CFG_DEFAULT;
         q_reg.tx_en <= `PRC_PAIR_NONE;
         q_reg.rx_en <= `PRC_PAIR_NONE;
      end else begin
         q_reg <= q_next;
      end
   end

   assign o_core_reset_n = q_reg.core_rst_n;
   assign o_ready = (q_reg.phase == prc_pkg::PRC_RUN);
   assign o_mac_clock_out_enable = q_reg.clk_out_en;
   assign o_mdix_active = q_reg.mdix;
   assign o_media_pair_tx_en = q_reg.tx_en;
   assign o_media_pair_rx_en = q_reg.rx_en;
   assign o_phy_addr = q_reg.phy_addr;
   assign o_config = q_reg.cfg;

   // Helper: cycles since a release while not yet running
   logic [`PRC_TMR_W:0] since_release;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         since_release <= '0;
      end else if (held || q_reg.phase == prc_pkg::PRC_RUN) begin
         since_release <= '0;
      end else begin
         since_release <= since_release + 1'b1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_running_10_100;
      q_next.phase == prc_pkg::PRC_RUN && !i_speed_gig;
   endsequence

   sequence s_release;
      held ##1 !held;
   endsequence

   chk_gig_all_pairs: assert property (
      q_next.phase == prc_pkg::PRC_RUN && i_speed_gig |=>
      o_media_pair_tx_en == `PRC_PAIR_ALL &&
      o_media_pair_rx_en == `PRC_PAIR_ALL)
      else $error("gigabit run without all four pairs both ways");

   chk_pair_zero_dir: assert property (
      s_running_10_100 |=>
      o_media_pair_tx_en[0] == !o_mdix_active &&
      o_media_pair_rx_en[0] == o_mdix_active)
      else $error("pair zero direction wrong for pairing");

   chk_pair_one_dir: assert property (
      s_running_10_100 |=>
      o_media_pair_tx_en[1] == o_mdix_active &&
      o_media_pair_rx_en[1] == !o_mdix_active)
      else $error("pair one direction wrong for pairing");

   chk_upper_pairs_idle: assert property (
      s_running_10_100 |=>
      (o_media_pair_tx_en & `PRC_PAIR_UPPER) == `PRC_PAIR_NONE &&
      (o_media_pair_rx_en & `PRC_PAIR_UPPER) == `PRC_PAIR_NONE)
      else $error("pairs two or three active at 10/100");

   chk_xover_hunt: assert property (
      q_reg.phase == prc_pkg::PRC_RUN && !held && q_reg.autox &&
      !i_link_ok && q_reg.xcnt == XOVER_LAST |=>
      o_mdix_active != $past(o_mdix_active))
      else $error("crossover hunt did not flip pairing");

   chk_xover_fixed: assert property (
      q_reg.phase == prc_pkg::PRC_RUN && !q_reg.autox |->
      o_mdix_active == q_reg.mdix_fixed)
      else $error("fixed pairing not taken from strap");

   chk_clk_in_reset: assert property (
      !i_hw_reset_n && !i_hw_powerdown_in |=>
      o_mac_clock_out_enable == !$past(i_mac_clock_enable_strap_n))
      else $error("clock out does not follow strap in reset");

   chk_clk_default_off: assert property (
      i_hw_reset_n && !q_next.clk_strap_en && !i_mgmt_clock_enable |=>
      !o_mac_clock_out_enable)
      else $error("clock out enabled with no request");

   chk_clk_mgmt_on: assert property (
      !held && q_next.phase == prc_pkg::PRC_RUN && i_mgmt_clock_enable
      |=> o_mac_clock_out_enable)
      else $error("management clock request ignored");

   chk_powerdown_idle: assert property (
      i_hw_powerdown_in |=> !o_core_reset_n && !o_ready &&
      o_media_pair_tx_en == `PRC_PAIR_NONE &&
      o_media_pair_rx_en == `PRC_PAIR_NONE && !o_mac_clock_out_enable)
      else $error("function active during powerdown");

   chk_strap_latch: assert property (
      q_reg.phase == prc_pkg::PRC_HELD && held |=>
      o_phy_addr == $past(i_phy_addr_strap) &&
      o_config == $past(i_config_strap))
      else $error("straps not latched while held");

   chk_settle_bound: assert property (
      since_release <= (`PRC_TMR_W + 1)'(SETTLE_CYCLES))
      else $error("reset completion exceeded its interval");

   chk_core_held: assert property (
      s_release |-> !o_core_reset_n [*2])
      else $error("core released right after pin release");

   chk_run_timer_idle: assert property (
      q_reg.phase == prc_pkg::PRC_RUN |-> !tmr.busy)
      else $error("settle timer still armed while running");

endmodule : phy_reset_clock_pair_map

`default_nettype wire

// [verif/prc_ctrl_model.sv]
// Controller and link partner model that drives the sequencer's pins
`default_nettype none

module prc_ctrl_model #(
   parameter int unsigned RESET_LOW_CYCLES = 800
) (
   input wire logic i_clk,           // Core clock
   input wire logic i_ready,         // Sequencer finished
   input wire logic i_mdix_active,   // Pairing now in use
   input wire logic i_cable_crossed, // Wiring the far end expects
   output logic o_hw_reset_n,        // Reset pin, low active
   output logic o_hw_powerdown_in,   // Powerdown pin, high active
   output logic o_link_ok,           // Link seen by the far end
   output logic o_crystal_in         // 25 MHz reference clock
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_hw_reset_n = 1'h1;
      o_hw_powerdown_in = 1'h0;
      o_link_ok = 1'h0;
      o_crystal_in = 1'h0;
   end

   // Board reference: 40 ns period, free running
   always #20 o_crystal_in = ~o_crystal_in;

   // Link only comes up once the pairing matches the cable
   always @(negedge i_clk) begin
      o_link_ok <= (i_ready === 1'h1) && (i_mdix_active === i_cable_crossed);
   end

   task automatic start_reset();
      @(negedge i_clk);
      o_hw_reset_n = 1'h0;
   endtask : start_reset

   // Never shorter than the minimum low time, whatever the caller does
   task automatic end_reset();
      repeat (RESET_LOW_CYCLES) @(negedge i_clk);
      o_hw_reset_n = 1'h1;
   endtask : end_reset

   task automatic set_powerdown(input logic on);
      @(negedge i_clk);
      o_hw_powerdown_in = on;
   endtask : set_powerdown
endmodule : prc_ctrl_model

`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the reset, clock-out and pair sequencer
`default_nettype none
`include "prc_defs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned SETTLE = 16;
   localparam int unsigned XOVER = 8;

   logic i_clk, i_resetn, hw_reset_n, hw_pd, strap_n, mgmt, autox;
   logic mdix_strap, speed_gig, link_ok, cable_crossed;
   logic core_reset_n, ready, clk_en, mdix_act;
   logic [`PRC_ADDR_W-1:0] addr_strap, phy_addr;
   logic [`PRC_CFG_W-1:0] cfg_strap, config_q;
   logic [`PRC_PAIRS-1:0] tx_en, rx_en;
   logic crystal_in;
   realtime t_ref;
   int fail_count = 0;
   int total_checks = 0;

   phy_reset_clock_pair_map #(
      .SETTLE_CYCLES(SETTLE),
      .XOVER_CYCLES(XOVER)
   ) phy_reset_clock_pair_map_inst (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_hw_reset_n(hw_reset_n),
      .i_hw_powerdown_in(hw_pd),
      .i_mac_clock_enable_strap_n(strap_n),
      .i_mgmt_clock_enable(mgmt),
      .i_autox_strap(autox),
      .i_mdix_strap(mdix_strap),
      .i_phy_addr_strap(addr_strap),
      .i_config_strap(cfg_strap),
      .i_speed_gig(speed_gig),
      .i_link_ok(link_ok),
      .o_core_reset_n(core_reset_n),
      .o_ready(ready),
      .o_mac_clock_out_enable(clk_en),
      .o_mdix_active(mdix_act),
      .o_media_pair_tx_en(tx_en),
      .o_media_pair_rx_en(rx_en),
      .o_phy_addr(phy_addr),
      .o_config(config_q)
   );

   prc_ctrl_model #(
      .RESET_LOW_CYCLES(800)
   ) prc_ctrl_model_inst (
      .i_clk(i_clk),
      .i_ready(ready),
      .i_mdix_active(mdix_act),
      .i_cable_crossed(cable_crossed),
      .o_hw_reset_n(hw_reset_n),
      .o_hw_powerdown_in(hw_pd),
      .o_link_ok(link_ok),
      .o_crystal_in(crystal_in)
   );

   always #12.5 i_clk = ~i_clk;

   task automatic results();
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen,
                  exp);
      end
   endtask : check

   // Counts falling edges until ready; gives up well past the settle time
   task automatic wait_ready(output int unsigned n);
      n = 0;
      while (ready !== 1'h1) begin
         @(negedge i_clk);
         n++;
         if (n > 1000) begin
            fail_count++;
            $display("MISMATCH t=%0t ready never rose", $time);
            results();
         end
      end
   endtask : wait_ready

   // Release lands on a falling edge: ready must show by the SETTLE-th
   // falling edge after it, and not more than one edge sooner
   task automatic check_settle(input int unsigned n);
      check(8'(n >= SETTLE - 1 && n <= SETTLE), 8'h01, "settle time");
   endtask : check_settle

   task automatic t_reset_seq();
      int unsigned n;
      @(negedge i_clk);
      addr_strap = 5'h15;
      cfg_strap = 8'hA5;
      prc_ctrl_model_inst.start_reset();
      repeat (3) @(negedge i_clk);
      check(8'(core_reset_n), 8'h00, "core held");
      check(8'(ready), 8'h00, "ready in reset");
      check(8'(phy_addr), 8'h15, "addr sampled");
      check(config_q, 8'hA5, "config sampled");
      prc_ctrl_model_inst.end_reset();
      addr_strap = 5'h0A;
      cfg_strap = 8'h5A;
      wait_ready(n);
      check_settle(n);
      check(8'(core_reset_n), 8'h01, "core released");
      check(8'(phy_addr), 8'h15, "addr kept");
      check(config_q, 8'hA5, "config kept");
   endtask : t_reset_seq

   task automatic t_clock_out();
      int unsigned n;
      @(negedge i_clk);
      strap_n = 1'h1;
      mgmt = 1'h1;
      prc_ctrl_model_inst.start_reset();
      repeat (2) @(negedge i_clk);
      check(8'(clk_en), 8'h00, "request ignored in reset");
      prc_ctrl_model_inst.end_reset();
      wait_ready(n);
      @(negedge i_clk);
      check(8'(clk_en), 8'h01, "request enables");
      mgmt = 1'h0;
      @(negedge i_clk);
      check(8'(clk_en), 8'h00, "request withdrawn");
      strap_n = 1'h0;
      prc_ctrl_model_inst.start_reset();
      repeat (2) @(negedge i_clk);
      check(8'(clk_en), 8'h01, "strap runs clock in reset");
      prc_ctrl_model_inst.end_reset();
      // Pin lets go with the reset pin; the latched value must hold
      strap_n = 1'h1;
      wait_ready(n);
      check(8'(clk_en), 8'h01, "strap latched");
      prc_ctrl_model_inst.set_powerdown(1'h1);
      addr_strap = 5'h1F;
      repeat (2) @(negedge i_clk);
      check(8'(clk_en), 8'h00, "clock off in powerdown");
      check(8'(core_reset_n), 8'h00, "core off");
      check(8'(tx_en | rx_en), 8'h00, "pairs off");
      check(8'(phy_addr), 8'h1F, "addr sampled");
      prc_ctrl_model_inst.set_powerdown(1'h0);
      wait_ready(n);
      check_settle(n);
      check(8'(clk_en), 8'h01, "strap kept");
   endtask : t_clock_out

   task automatic t_fixed_pairs();
      int unsigned n;
      for (int m = 0; m < 2; m++) begin
         @(negedge i_clk);
         autox = 1'h0;
         mdix_strap = m[0];
         speed_gig = 1'h0;
         prc_ctrl_model_inst.start_reset();
         prc_ctrl_model_inst.end_reset();
         wait_ready(n);
         repeat (3 * XOVER) @(negedge i_clk);
         check(8'(mdix_act), 8'(m), "fixed pairing");
         check(8'(tx_en), m ? 8'h02 : 8'h01, "tx 10/100");
         check(8'(rx_en), m ? 8'h01 : 8'h02, "rx 10/100");
         check(8'((tx_en | rx_en) & 4'hC), 8'h00, "upper idle");
         speed_gig = 1'h1;
         @(negedge i_clk);
         check(8'(tx_en), 8'h0F, "tx gig");
         check(8'(rx_en), 8'h0F, "rx gig");
      end
   endtask : t_fixed_pairs

   task automatic t_auto_pairs();
      int unsigned n;
      @(negedge i_clk);
      autox = 1'h1;
      cable_crossed = 1'h1;
      speed_gig = 1'h0;
      prc_ctrl_model_inst.start_reset();
      prc_ctrl_model_inst.end_reset();
      wait_ready(n);
      n = 0;
      while (link_ok !== 1'h1 && n < 4 * XOVER) begin
         @(negedge i_clk);
         n++;
      end
      check(8'(link_ok), 8'h01, "link found");
      repeat (3 * XOVER) @(negedge i_clk);
      check(8'(mdix_act), 8'h01, "crossed held");
      check(8'(tx_en), 8'h02, "tx crossed");
      check(8'(rx_en), 8'h01, "rx crossed");
   endtask : t_auto_pairs

   initial begin
      i_clk = 1'h0;
      i_resetn = 1'h0;
      strap_n = 1'h1;
      mgmt = 1'h0;
      autox = 1'h1;
      mdix_strap = 1'h0;
      addr_strap = 5'h00;
      cfg_strap = 8'h00;
      speed_gig = 1'h0;
      cable_crossed = 1'h0;
      repeat (5) @(negedge i_clk);
      check(8'(clk_en), 8'h00, "clock off at reset");
      i_resetn = 1'h1;
      @(posedge crystal_in);
      t_ref = $realtime;
      @(posedge crystal_in);
      check(8'(int'($realtime - t_ref)), 8'h28, "ref period");
      t_reset_seq();
      t_clock_out();
      t_fixed_pairs();
      t_auto_pairs();
      results();
   end
endmodule : testbench

`default_nettype wire
